// ==== include/servo_param_pkg.sv ====
`default_nettype none

package servo_param_pkg;

   // ==========================================================
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PARAM_W = 16;
   localparam int GEAR_W = 21;

   // ==========================================================
   // Address map: addr[7:6] is the group, addr[5:0] the index
   localparam logic [1:0] GRP_BASIC = 2'h0;
   localparam logic [1:0] GRP_GAIN = 2'h1;
   localparam logic [1:0] GRP_EXT = 2'h2;
   localparam logic [1:0] GRP_IO = 2'h3;
   localparam logic [5:0] IDX_MODE = 6'h01;
   localparam logic [5:0] IDX_REGEN = 6'h02;
   localparam logic [5:0] IDX_ABS = 6'h03;
   localparam logic [5:0] IDX_PIN = 6'h04;
   localparam logic [5:0] IDX_PPT = 6'h05;
   localparam logic [5:0] IDX_GEAR_NUM = 6'h06;
   localparam logic [5:0] IDX_GEAR_DEN = 6'h07;
   localparam logic [5:0] IDX_BLOCK = 6'h13;
   localparam logic [5:0] IDX_STATUS = 6'h30;
   localparam logic [5:0] IDX_IRQ_EN = 6'h31;
   localparam logic [5:0] IDX_IRQ_CLR = 6'h32;

   // ==========================================================
   // Values after reset
   localparam logic [15:0] BLOCK_RESET = 16'h000b;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] REGEN_RESET = 16'h0000;
   localparam logic [15:0] ABS_RESET = 16'h0000;
   localparam logic [15:0] PIN_RESET = 16'h0000;
   localparam logic [15:0] PPT_RESET = 16'h0000;
   localparam logic [20:0] GEAR_RESET = 21'h000001;

   // ==========================================================
   // Group access codes
   localparam logic [15:0] BLK_BASIC = 16'h0000;
   localparam logic [15:0] BLK_NO_IO = 16'h000b;
   localparam logic [15:0] BLK_ALL = 16'h000c;
   localparam logic [15:0] BLK_LOCK_BASIC = 16'h100b;
   localparam logic [15:0] BLK_LOCK_ALL = 16'h100c;

   // ==========================================================
   // Ranges
   localparam logic [15:0] PPT_MIN = 16'h03e8;
   localparam logic [15:0] PPT_MAX = 16'hc350;
   localparam logic [20:0] GEAR_MIN = 21'h000001;
   localparam logic [20:0] GEAR_MAX = 21'h100000;
   localparam logic [3:0] MODE_LAST = 4'h5;
   localparam logic [3:0] ABS_LAST = 4'h2;
   localparam logic [3:0] PIN_LAST = 4'h1;

   // ==========================================================
   // Status bits
   localparam int ST_WR_REFUSED = 0;
   localparam int ST_RANGE = 1;
   localparam int ST_ALARM = 2;
   localparam int ST_W = 3;

   typedef enum logic [3:0] {
      MODE_POS,
      MODE_POS_SPD,
      MODE_SPD,
      MODE_SPD_TRQ,
      MODE_TRQ,
      MODE_TRQ_POS
   } ctrl_mode_t;

endpackage : servo_param_pkg

`default_nettype wire

// ==== rtl/latched_param.sv ====
`timescale 1ns/100ps
`default_nettype none

// A setting held in two stages: what software wrote, and what the
// amplifier acts on, which follows only at the next power restore.
module latched_param
   import servo_param_pkg::*;
#(
   parameter int          W    = 16,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wr_data,
   input  wire logic         apply,
   output logic      [W-1:0] stored,
   output logic      [W-1:0] active
);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stored <= INIT;
      end else if (wr_en) begin
         stored <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         active <= INIT;
      end else if (apply) begin
         active <= stored;
      end
   end

endmodule : latched_param

`default_nettype wire

// ==== rtl/servo_basic_param_bank.sv ====
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Access code 0000h opens only the basic group, 000Bh adds gain/filter and extension, 000Ch opens all four groups.
// - Codes 100Bh and 100Ch read the basic group or all groups respectively, and accept writes only to the access selector.
// - After initialisation the access selector holds 000Bh, so the I/O group is closed.
// - New values of the access selector and the five starred settings act only after a power restore.
// - Control mode 0..5 selects position, position/speed, speed, speed/torque, torque, torque/position; default 0.
// - A regenerative option that does not suit this amplifier raises the parameter error alarm.
// - Absolute selection 0 is incremental, 1 absolute with transfer on digital inputs, 2 absolute by communication.
// - Absolute detection acts only while the amplifier runs position control.
// - Pin function 0 routes the assigned output device to the pin, 1 drives the brake interlock there.
// - Pulses per turn accepts only 0 or 1000 through 50000, default 0.
// - Pulses per turn of 0 selects the gear ratio, a nonzero value sets pulses per turn and disables the gear.
// - Gear numerator and denominator accept 1 through 1048576, each defaulting to 1.
module servo_basic_param_bank
   import servo_param_pkg::*;
#(
   parameter logic [15:0] REGEN_OK_MASK = 16'h0001
) (
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [DATA_W-1:0] rdata,
   input  wire logic              power_restore,
   input  wire logic              mode_alt,
   input  wire logic              brake_interlock_output,
   input  wire logic              assigned_output,
   output logic                   dedicated_pin,
   output logic                   position_ctrl,
   output logic                   speed_ctrl,
   output logic                   torque_ctrl,
   output logic                   abs_active,
   output logic                   digital_input_transfer,
   output logic                   abs_by_comm,
   output logic                   parameter_error_alarm,
   output logic                   use_gear,
   output logic      [15:0]       cmd_pulses_per_turn,
   output logic      [GEAR_W-1:0] gear_numerator,
   output logic      [GEAR_W-1:0] gear_denominator,
   output logic      [3:0]        group_read_ok,
   output logic      [3:0]        group_write_ok,
   output logic                   irq
);

   // ==========================================================
   // Settings that wait for a power restore
   logic [15:0] blk_st, blk_act, mode_st, mode_act, regen_st, regen_act;
   logic [15:0] abs_st, abs_act, pin_st, pin_act, ppt_st, ppt_act;
   logic        wr_blk, wr_mode, wr_regen, wr_abs, wr_pin, wr_ppt;

   latched_param #(.W(16), .INIT(BLOCK_RESET)) u_blk (
      .clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_blk), .wr_data(wdata[15:0]),
      .apply(power_restore), .stored(blk_st), .active(blk_act));
   latched_param #(.W(16), .INIT(MODE_RESET)) u_mode (
      .clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_mode), .wr_data(wdata[15:0]),
      .apply(power_restore), .stored(mode_st), .active(mode_act));
   latched_param #(.W(16), .INIT(REGEN_RESET)) u_regen (
      .clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_regen), .wr_data(wdata[15:0]),
      .apply(power_restore), .stored(regen_st), .active(regen_act));
   latched_param #(.W(16), .INIT(ABS_RESET)) u_abs (
      .clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_abs), .wr_data(wdata[15:0]),
      .apply(power_restore), .stored(abs_st), .active(abs_act));
   latched_param #(.W(16), .INIT(PIN_RESET)) u_pin (
      .clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_pin), .wr_data(wdata[15:0]),
      .apply(power_restore), .stored(pin_st), .active(pin_act));
   latched_param #(.W(16), .INIT(PPT_RESET)) u_ppt (
      .clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_ppt), .wr_data(wdata[15:0]),
      .apply(power_restore), .stored(ppt_st), .active(ppt_act));

   // ==========================================================
   // Group access decode from the acting selector
   logic [3:0] next_rd_ok, next_wr_ok;
   logic       blk_only;

   always_comb begin
      next_rd_ok = 4'h1;
      next_wr_ok = 4'h0;
      blk_only   = 1'b1;
      case (blk_act)
         BLK_BASIC: begin
            next_wr_ok = 4'h1;
            blk_only   = 1'b0;
         end
         BLK_NO_IO: begin
            next_rd_ok = 4'h7;
            next_wr_ok = 4'h7;
            blk_only   = 1'b0;
         end
         BLK_ALL: begin
            next_rd_ok = 4'hf;
            next_wr_ok = 4'hf;
            blk_only   = 1'b0;
         end
         BLK_LOCK_ALL: begin
            next_rd_ok = 4'hf;
         end
         // Unknown codes fall back to the locked basic view, so the
         // selector itself can always be rewritten to recover.
         default: begin
            next_rd_ok = 4'h1;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         group_read_ok  <= 4'h7;
         group_write_ok <= 4'h7;
      end else begin
         group_read_ok  <= next_rd_ok;
         group_write_ok <= next_wr_ok;
      end
   end

   // ==========================================================
   // Write decode and range checks
   logic [1:0]  grp;
   logic [5:0]  idx;
   logic        is_param, is_ctl, wr_allowed, range_ok, param_wr;
   logic [GEAR_W-1:0] gear_num_st, gear_den_st;

   assign grp      = addr[7:6];
   assign idx      = addr[5:0];
   assign is_ctl   = (grp == GRP_BASIC) && (idx == IDX_STATUS || idx == IDX_IRQ_EN ||
                                            idx == IDX_IRQ_CLR);
   assign is_param = !is_ctl;

   always_comb begin
      wr_allowed = next_wr_ok[grp] || (grp == GRP_BASIC && idx == IDX_BLOCK);
      if (blk_only && !(grp == GRP_BASIC && idx == IDX_BLOCK)) begin
         wr_allowed = 1'b0;
      end
   end

   always_comb begin
      range_ok = 1'b1;
      if (grp == GRP_BASIC && idx == IDX_PPT) begin
         range_ok = (wdata[31:16] == 16'h0000) && ((wdata[15:0] == 16'h0000) ||
                    (wdata[15:0] >= PPT_MIN && wdata[15:0] <= PPT_MAX));
      end else if (grp == GRP_BASIC && (idx == IDX_GEAR_NUM || idx == IDX_GEAR_DEN)) begin
         range_ok = (wdata[31:GEAR_W] == 11'h000) && (wdata[GEAR_W-1:0] >= GEAR_MIN) &&
                    (wdata[GEAR_W-1:0] <= GEAR_MAX);
      end
   end

   assign param_wr = wr && is_param && wr_allowed && range_ok;
   assign wr_blk   = param_wr && grp == GRP_BASIC && idx == IDX_BLOCK;
   assign wr_mode  = param_wr && grp == GRP_BASIC && idx == IDX_MODE;
   assign wr_regen = param_wr && grp == GRP_BASIC && idx == IDX_REGEN;
   assign wr_abs   = param_wr && grp == GRP_BASIC && idx == IDX_ABS;
   assign wr_pin   = param_wr && grp == GRP_BASIC && idx == IDX_PIN;
   assign wr_ppt   = param_wr && grp == GRP_BASIC && idx == IDX_PPT;

   // The gear ratio is not a starred setting, so it acts at once.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         gear_num_st <= GEAR_RESET;
         gear_den_st <= GEAR_RESET;
      end else if (param_wr && grp == GRP_BASIC && idx == IDX_GEAR_NUM) begin
         gear_num_st <= wdata[GEAR_W-1:0];
      end else if (param_wr && grp == GRP_BASIC && idx == IDX_GEAR_DEN) begin
         gear_den_st <= wdata[GEAR_W-1:0];
      end
   end

   // ==========================================================
   // Decode of the acting settings
   logic bad_setting, pos_now;

   always_comb begin
      case (ctrl_mode_t'(mode_act[3:0]))
         MODE_POS:     pos_now = 1'b1;
         MODE_POS_SPD: pos_now = !mode_alt;
         MODE_TRQ_POS: pos_now = mode_alt;
         default:      pos_now = 1'b0;
      endcase
   end

   assign bad_setting = !REGEN_OK_MASK[regen_act[3:0]] || (regen_act[15:4] != 12'h000) ||
                        (mode_act[15:4] != 12'h000) || (mode_act[3:0] > MODE_LAST) ||
                        (abs_act[15:4] != 12'h000) || (abs_act[3:0] > ABS_LAST) ||
                        (pin_act[15:4] != 12'h000) || (pin_act[3:0] > PIN_LAST);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         position_ctrl <= 1'b1;
         speed_ctrl    <= 1'b0;
         torque_ctrl   <= 1'b0;
      end else begin
         position_ctrl <= pos_now;
         speed_ctrl    <= (mode_act[3:0] == 4'h2) || (mode_act[3:0] == 4'h1 && mode_alt) ||
                          (mode_act[3:0] == 4'h3 && !mode_alt);
         torque_ctrl   <= (mode_act[3:0] == 4'h4) || (mode_act[3:0] == 4'h3 && mode_alt) ||
                          (mode_act[3:0] == 4'h5 && !mode_alt);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         abs_active             <= 1'b0;
         digital_input_transfer <= 1'b0;
         abs_by_comm            <= 1'b0;
      end else begin
         abs_active             <= pos_now && abs_act inside {16'h0001, 16'h0002};
         digital_input_transfer <= pos_now && abs_act == 16'h0001;
         abs_by_comm            <= pos_now && abs_act == 16'h0002;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dedicated_pin <= 1'b0;
      end else begin
         dedicated_pin <= (pin_act == 16'h0001) ? brake_interlock_output : assigned_output;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         parameter_error_alarm <= 1'b0;
      end else begin
         parameter_error_alarm <= bad_setting;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         use_gear            <= 1'b1;
         cmd_pulses_per_turn <= PPT_RESET;
         gear_numerator      <= GEAR_RESET;
         gear_denominator    <= GEAR_RESET;
      end else begin
         use_gear            <= (ppt_act == 16'h0000);
         cmd_pulses_per_turn <= ppt_act;
         gear_numerator      <= gear_num_st;
         gear_denominator    <= gear_den_st;
      end
   end

   // ==========================================================
   // Events, status and interrupt
   logic [ST_W-1:0] status, irq_en, ev, clr;
   logic            alarm_d;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         alarm_d <= 1'b0;
      end else begin
         alarm_d <= parameter_error_alarm;
      end
   end

   assign ev[ST_WR_REFUSED] = wr && is_param && !wr_allowed;
   assign ev[ST_RANGE]      = wr && is_param && wr_allowed && !range_ok;
   assign ev[ST_ALARM]      = parameter_error_alarm && !alarm_d;
   assign clr = (wr && grp == GRP_BASIC && idx == IDX_IRQ_CLR) ? wdata[ST_W-1:0] : '0;

   // A new event in the clearing cycle stays set.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         status <= '0;
      end else begin
         status <= (status & ~clr) | ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_en <= '0;
      end else if (wr && grp == GRP_BASIC && idx == IDX_IRQ_EN) begin
         irq_en <= wdata[ST_W-1:0];
      end
   end

   assign irq = |(status & irq_en);

   // ==========================================================
   // Read port, data one cycle after the strobe
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (grp == GRP_BASIC) begin
         case (idx)
            IDX_MODE:     next_rdata = {16'h0000, mode_st};
            IDX_REGEN:    next_rdata = {16'h0000, regen_st};
            IDX_ABS:      next_rdata = {16'h0000, abs_st};
            IDX_PIN:      next_rdata = {16'h0000, pin_st};
            IDX_PPT:      next_rdata = {16'h0000, ppt_st};
            IDX_GEAR_NUM: next_rdata = {11'h000, gear_num_st};
            IDX_GEAR_DEN: next_rdata = {11'h000, gear_den_st};
            IDX_BLOCK:    next_rdata = {16'h0000, blk_st};
            IDX_STATUS:   next_rdata = {29'h0, status};
            IDX_IRQ_EN:   next_rdata = {29'h0, irq_en};
            default:      next_rdata = '0;
         endcase
      end
      // Other groups live outside this bank and read zero here whether
      // open or closed, so a closed group never leaks content.
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (rd) begin
         rdata <= next_rdata;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_locked_write;
      blk_act == BLK_LOCK_BASIC && wr && addr == {GRP_BASIC, IDX_MODE};
   endsequence

   a_factory_block: assert property ($rose(rstn) |-> blk_act == BLOCK_RESET)
      else $error("access selector not at factory value after reset");
   a_all_groups: assert property (blk_act == BLK_ALL |=> group_write_ok == 4'hf)
      else $error("code 000ch does not open every group");
   a_lock_write: assert property (s_locked_write |=> $stable(mode_st))
      else $error("locked selector let a mode write through");
   a_hold_until_on: assert property (!power_restore |=> $stable({mode_act, blk_act}))
      else $error("setting acted without a power restore");
   a_torque_mode: assert property (mode_act == 16'h0004 && !power_restore |=>
                                   torque_ctrl && !position_ctrl && !speed_ctrl)
      else $error("mode 4 not decoded as torque");
   a_regen_alarm: assert property (!REGEN_OK_MASK[regen_act[3:0]] |=> parameter_error_alarm)
      else $error("unsuited regen option raised no alarm");
   a_abs_di: assert property (abs_act == 16'h0001 && pos_now && !power_restore |=>
                              digital_input_transfer && !abs_by_comm)
      else $error("absolute code 1 not decoded");
   a_abs_pos_only: assert property (!position_ctrl |-> !abs_active && !abs_by_comm)
      else $error("absolute detection active outside position control");
   a_pin_brake: assert property (pin_act == 16'h0001 && !power_restore |=>
                                 dedicated_pin == $past(brake_interlock_output))
      else $error("pin does not carry brake interlock");
   a_ppt_range: assert property (wr && addr == {GRP_BASIC, IDX_PPT} && wdata > 32'h0000c350
                                 |=> $stable(ppt_st))
      else $error("out of range pulses per turn stored");
   a_gear_off: assert property (ppt_act != 16'h0000 && !power_restore |=> !use_gear)
      else $error("gear stays valid with pulses per turn set");
   a_gear_range: assert property (gear_num_st >= GEAR_MIN && gear_den_st <= GEAR_MAX)
      else $error("gear value outside range");
   a_closed_write: assert property (wr && is_param && !wr_allowed |=>
                                    $stable(ppt_st) && status[ST_WR_REFUSED])
      else $error("closed group write not refused");

endmodule : servo_basic_param_bank

`default_nettype wire

// ==== verif/servo_basic_param_bank_test.sv ====
`timescale 1ns/100ps
`default_nettype none

module servo_basic_param_bank_test;
   import servo_param_pkg::*;

   logic              clk_sys;
   logic              rstn;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              power_restore;
   logic              mode_alt;
   logic              brake_interlock_output;
   logic              assigned_output;
   logic              dedicated_pin;
   logic              position_ctrl;
   logic              speed_ctrl;
   logic              torque_ctrl;
   logic              abs_active;
   logic              digital_input_transfer;
   logic              abs_by_comm;
   logic              parameter_error_alarm;
   logic              use_gear;
   logic [15:0]       cmd_pulses_per_turn;
   logic [GEAR_W-1:0] gear_numerator;
   logic [GEAR_W-1:0] gear_denominator;
   logic [3:0]        group_read_ok;
   logic [3:0]        group_write_ok;
   logic              irq;
   int                failures;
   int                tests_run;
   logic [31:0]       v;

   servo_basic_param_bank i_servo_basic_param_bank (
      .clk_sys, .rstn, .addr, .wdata, .wr, .rd, .rdata, .power_restore, .mode_alt,
      .brake_interlock_output, .assigned_output, .dedicated_pin, .position_ctrl,
      .speed_ctrl, .torque_ctrl, .abs_active, .digital_input_transfer, .abs_by_comm,
      .parameter_error_alarm, .use_gear, .cmd_pulses_per_turn, .gear_numerator,
      .gear_denominator, .group_read_ok, .group_write_ok, .irq
   );

   // ==========================================================
   // Bus and check tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic reg_wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] g = 2'h0);
      @(posedge clk_sys);
      addr  <= {g, idx};
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr    <= 1'b0;
   endtask : reg_wr

   // Read data appear at the edge after the strobe and hold until the next strobe, so sample just after that edge.
   task automatic reg_rd(input logic [5:0] idx, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= {GRP_BASIC, idx};
      rd   <= 1'b1;
      @(posedge clk_sys);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      reg_rd(idx, d);
      chk(what, exp, d);
   endtask : rd_chk

   task automatic restore;
      @(posedge clk_sys);
      power_restore <= 1'b1;
      @(posedge clk_sys);
      power_restore <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : restore

   task automatic settle;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : settle

   function automatic logic [2:0] mode_exp(input int m, input logic alt);
      case (m)
         0: return 3'b100;
         1: return alt ? 3'b010 : 3'b100;
         2: return 3'b010;
         3: return alt ? 3'b001 : 3'b010;
         4: return 3'b001;
         default: return alt ? 3'b100 : 3'b001;
      endcase
   endfunction : mode_exp

   task automatic print_verdict;
      $display("Counts: %0d checks, %0d failures", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // ==========================================================
   // Clock, watchdog and stimulus
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (50000) @(posedge clk_sys);
      failures++;
      print_verdict();
   end

   initial begin
      logic [31:0] ppt_in [5];
      logic [31:0] ppt_rb [5];
      logic [15:0] codes [5];
      logic [3:0]  rok [5];
      logic [31:0] mode_st;
      ppt_in = '{32'h3e8, 32'h3e7, 32'hc351, 32'h103e8, 32'hc350};
      ppt_rb = '{32'h3e8, 32'h3e8, 32'h3e8, 32'h3e8, 32'hc350};
      codes = '{16'h0000, 16'h000b, 16'h000c, 16'h100b, 16'h100c};
      rok = '{4'h1, 4'h7, 4'hf, 4'h1, 4'hf};
      failures = 0;
      tests_run = 0;
      rstn = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      power_restore = 1'b0;
      mode_alt = 1'b0;
      brake_interlock_output = 1'b0;
      assigned_output = 1'b0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_chk("selector", IDX_BLOCK, 32'h0000000b);
      chk("read_ok", 32'h7, {28'h0, group_read_ok});
      rd_chk("ppt", IDX_PPT, 32'h0);
      rd_chk("gear_num", IDX_GEAR_NUM, 32'h1);
      rd_chk("gear_den", IDX_GEAR_DEN, 32'h1);
      chk("use_gear", 32'h1, {31'h0, use_gear});
      $display("test reset values done");
      reg_wr(IDX_MODE, 32'h2);
      settle();
      chk("mode_early", 32'h4, {29'h0, position_ctrl, speed_ctrl, torque_ctrl});
      for (int m = 0; m < 6; m++) begin
         reg_wr(IDX_MODE, 32'(m));
         restore();
         for (int a = 0; a < 2; a++) begin
            @(posedge clk_sys);
            mode_alt <= a[0];
            settle();
            v = {29'h0, position_ctrl, speed_ctrl, torque_ctrl};
            chk("mode", {29'h0, mode_exp(m, a[0])}, v);
         end
      end
      @(posedge clk_sys);
      mode_alt <= 1'b0;
      $display("test control modes done");
      reg_wr(IDX_MODE, 32'h0);
      for (int s = 0; s < 4; s++) begin
         // The last pass leaves absolute detection selected but moves to speed control.
         reg_wr(IDX_ABS, (s == 3) ? 32'h2 : 32'(s));
         if (s == 3) reg_wr(IDX_MODE, 32'h2);
         restore();
         v = {29'h0, abs_active, digital_input_transfer, abs_by_comm};
         chk("abs", (s == 3) ? 32'h0 : {29'h0, s != 0, s == 1, s == 2}, v);
      end
      $display("test absolute detection done");
      for (int p = 0; p < 4; p++) begin
         reg_wr(IDX_PIN, {31'h0, p[1]});
         restore();
         @(posedge clk_sys);
         brake_interlock_output <= p[0];
         assigned_output <= ~p[0];
         settle();
         chk("pin", {31'h0, p[1] ? p[0] : ~p[0]}, {31'h0, dedicated_pin});
      end
      $display("test pin function done");
      for (int i = 0; i < 5; i++) begin
         reg_wr(IDX_IRQ_CLR, 32'h7);
         reg_wr(IDX_PPT, ppt_in[i]);
         rd_chk("ppt_store", IDX_PPT, ppt_rb[i]);
         reg_rd(IDX_STATUS, v);
         chk("range_flag", {31'h0, ppt_rb[i] !== ppt_in[i]}, {31'h0, v[ST_RANGE]});
      end
      restore();
      chk("ppt_act", 32'hc350, {16'h0, cmd_pulses_per_turn});
      chk("gear_off", 32'h0, {31'h0, use_gear});
      reg_wr(IDX_GEAR_NUM, 32'h100000);
      reg_wr(IDX_GEAR_NUM, 32'h0);
      reg_wr(IDX_GEAR_DEN, 32'h100001);
      settle();
      chk("gear_num", 32'h100000, {11'h0, gear_numerator});
      chk("gear_den", 32'h1, {11'h0, gear_denominator});
      $display("test pulses and gear done");
      reg_wr(IDX_IRQ_CLR, 32'h7);
      reg_wr(IDX_REGEN, 32'h5);
      restore();
      chk("alarm", 32'h1, {31'h0, parameter_error_alarm});
      chk("irq_masked", 32'h0, {31'h0, irq});
      reg_wr(IDX_IRQ_EN, 32'h4);
      settle();
      chk("irq_on", 32'h1, {31'h0, irq});
      reg_wr(IDX_IRQ_CLR, 32'h4);
      settle();
      chk("irq_clr", 32'h0, {31'h0, irq});
      reg_wr(IDX_REGEN, 32'h0);
      restore();
      chk("alarm_off", 32'h0, {31'h0, parameter_error_alarm});
      $display("test alarm done");
      mode_st = 32'h2;
      for (int i = 0; i < 5; i++) begin
         reg_wr(IDX_BLOCK, {16'h0, codes[i]});
         settle();
         chk("sel_early", {28'h0, (i == 0) ? 4'h7 : rok[i-1]}, {28'h0, group_read_ok});
         restore();
         chk("read_ok", {28'h0, rok[i]}, {28'h0, group_read_ok});
         chk("write_ok", {28'h0, codes[i][12] ? 4'h0 : rok[i]},
             {28'h0, group_write_ok});
         reg_wr(IDX_MODE, 32'(i));
         if (!codes[i][12]) mode_st = 32'(i);
         rd_chk("locked_mode", IDX_MODE, mode_st);
         reg_wr(IDX_IRQ_CLR, 32'h7);
         reg_wr(6'h01, 32'h5, GRP_IO);
         reg_rd(IDX_STATUS, v);
         chk("io_write", {31'h0, codes[i][12] | (rok[i] != 4'hf)},
             {31'h0, v[ST_WR_REFUSED]});
      end
      $display("test group access done");
      print_verdict();
   end

endmodule : servo_basic_param_bank_test

`default_nettype wire
